//--- include/ells_regs.svh
// register offsets, reset values, setting codes and timing figures of the
// ethernet link loss supervisor; assumes a 32-bit wishbone slave, byte addresses
`ifndef ELLS_REGS_SVH
`define ELLS_REGS_SVH

// byte offsets, one 32-bit word each
`define ELLS_OFF_PRIMARY   8'h00
`define ELLS_OFF_EXTENDED  8'h04
`define ELLS_OFF_MASK1     8'h08
`define ELLS_OFF_MASK2     8'h0C
`define ELLS_OFF_MASK3     8'h10
`define ELLS_OFF_MASK4     8'h14
`define ELLS_OFF_KEEPALIVE 8'h18
`define ELLS_OFF_DIAG      8'h1C
`define ELLS_OFF_RELAY     8'h20
`define ELLS_OFF_IRQ_STAT  8'h24
`define ELLS_OFF_IRQ_MASK  8'h28
`define ELLS_OFF_CONTROL   8'h2C
`define ELLS_OFF_LIVE      8'h30

// reset values
`define ELLS_RST_PRIMARY   16'h0003
`define ELLS_RST_EXTENDED  16'h270F
`define ELLS_RST_MASK_HI   16'h00FF
`define ELLS_RST_MASK_LO   16'h0000
`define ELLS_RST_KEEPALIVE 16'h003C
`define ELLS_RST_DIAG      16'h270F
`define ELLS_RST_RELAY     16'h0000
`define ELLS_RST_IRQ_MASK  4'h0

// setting codes
`define ELLS_ACT_OFF       16'h0000
`define ELLS_ACT_WARN      16'h0001
`define ELLS_ACT_ALARM     16'h0002
`define ELLS_ACT_TRIP      16'h0003
`define ELLS_EXT_BOTH      16'h22B8
`define ELLS_EXT_EITHER    16'h270F
`define ELLS_DIAG_OFF      16'h0000
`define ELLS_DIAG_SNMP     16'h0001
`define ELLS_DIAG_DUPIP    16'h0002
`define ELLS_DIAG_ALL      16'h270F
`define ELLS_RELAY_ON      16'h270F
`define ELLS_FUNC_FIELDBUS 16'h8892
`define ELLS_KA_MIN        16'h0001
`define ELLS_KA_MAX        16'h1C20
`define ELLS_OCTET_MAX     16'h00FF

// field positions
`define ELLS_IRQ_WARN      0
`define ELLS_IRQ_ALARM     1
`define ELLS_IRQ_TRIP      2
`define ELLS_IRQ_CLOSE     3
`define ELLS_CTL_TRIP_CLR  0

// timing
`define ELLS_CLK_PERIOD_NS 10
`define ELLS_SECOND_NS     1000000000
`define ELLS_KA_MULT       8

`endif

//--- include/ells_pkg.sv
// types of the ethernet link loss supervisor
// assumes ells_regs.svh supplies the numbers; this package holds shapes only
package ells_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ells_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ells_wb_rsp_t;

    typedef struct packed {
        logic        link_loss_warning;
        logic        alarm_output;
        logic        link_loss_trip;
    } ells_ind_t;

    typedef struct packed {
        logic [15:0]       primary_loss_action;
        logic [15:0]       extended_loss_action;
        logic [3:0][15:0]  staged_mask;
        logic [3:0][7:0]   active_mask;
        logic [15:0]       keepalive_seconds;
        logic [15:0]       network_diagnosis_select;
        logic [15:0]       relay_at_reset_select;
        logic [3:0]        irq_status;
        logic [3:0]        irq_mask;
        logic              first_port_s1;
        logic              first_port_s2;
        logic              second_port_s1;
        logic              second_port_s2;
        ells_ind_t         ind;
        logic [15:0]       stop_mode;
        logic              force_close;
        logic [31:0]       ka_prescale;
        logic [15:0]       ka_seconds;
        logic              snmp_enable;
        logic              dup_ip_enable;
        ells_wb_rsp_t      rsp;
    } ells_state_t;

endpackage

//--- rtl/ells_top.sv
// ethernet link loss supervisor: loss response, keep-alive watchdog, settings
// assumes loss pins come straight from the phys; all other inputs share clk
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`include "ells_regs.svh"

module ells_top #(
    parameter int unsigned CYCLES_PER_SEC = `ELLS_SECOND_NS / `ELLS_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // register bus
    input  wire ells_pkg::ells_wb_req_t wb_req,
    output      ells_pkg::ells_wb_rsp_t wb_rsp,
    output      logic                  irq,
    // phy pins, asynchronous
    input  wire logic                  first_port_loss,
    input  wire logic                  second_port_loss,
    // drive side, same clock
    input  wire logic                  drive_stopped,
    input  wire logic                  drive_reset,
    input  wire logic                  fieldbus_cyclic,
    input  wire logic [3:0][15:0]      function_select,
    input  wire logic [15:0]           comm_error_stop_mode,
    input  wire logic                  connection_open,
    input  wire logic                  keepalive_ack,
    // indications and controls
    output      ells_pkg::ells_ind_t   ind,
    output      logic [15:0]           stop_mode,
    output      logic                  force_close,
    output      logic                  snmp_enable,
    output      logic                  dup_ip_enable,
    output      logic [31:0]           subnet_mask,
    output      logic                  relay_at_reset
);
    import ells_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    ells_state_t s;
    ells_state_t next_s;

    // {trip, alarm, warning} that one code asks for when its loss is present
    function automatic logic [2:0] ells_act(input logic [15:0] code, input logic hit);
        logic [2:0] r;
        r = 3'h0;
        if (hit) begin
            case (code)
                `ELLS_ACT_WARN:  r = 3'h1;
                `ELLS_ACT_ALARM: r = 3'h3;
                `ELLS_ACT_TRIP:  r = 3'h4;
                default:         r = 3'h0;
            endcase
        end
        return r;
    endfunction

    function automatic logic ells_act_ok(input logic [15:0] v);
        return v <= `ELLS_ACT_TRIP;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // loss decision

    logic        loss1;
    logic        loss2;
    logic [2:0]  want;
    logic        want_trip;
    logic        fieldbus_trip;
    logic        fieldbus_func;

    assign loss1 = s.first_port_s2;
    assign loss2 = s.second_port_s2;

    always_comb begin
        case (s.extended_loss_action)
            `ELLS_EXT_BOTH:   want = ells_act(s.primary_loss_action, loss1 & loss2);
            `ELLS_EXT_EITHER: want = ells_act(s.primary_loss_action, loss1 | loss2);
            default:          want = ells_act(s.primary_loss_action, loss1)
                                   | ells_act(s.extended_loss_action, loss2);
        endcase
    end

    assign fieldbus_trip = fieldbus_cyclic & (loss1 | loss2);
    assign want_trip     = (want[2] & ~drive_stopped) | fieldbus_trip;

    always_comb begin
        fieldbus_func = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (function_select[i] == `ELLS_FUNC_FIELDBUS) begin
                fieldbus_func = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        req;
    logic        wr;
    logic        rd;
    logic        wr16;
    logic [15:0] wv;
    logic [7:0]  a;
    logic [31:0] rdata;
    logic [15:0] ka_limit;
    logic        ka_second;
    logic [3:0]  ev;

    assign req  = wb_req.cyc & wb_req.stb & ~s.rsp.ack;
    assign wr   = req & wb_req.we;
    assign rd   = req & ~wb_req.we;
    // 16-bit settings change only when both low byte lanes are written
    assign wr16 = wr & (wb_req.sel[1:0] == 2'h3);
    assign wv   = wb_req.dat[15:0];
    assign a    = {wb_req.adr[7:2], 2'h0};

    always_comb begin
        rdata = 32'h0;
        case (a)
            `ELLS_OFF_PRIMARY:   rdata[15:0] = s.primary_loss_action;
            `ELLS_OFF_EXTENDED:  rdata[15:0] = s.extended_loss_action;
            `ELLS_OFF_MASK1:     rdata[15:0] = s.staged_mask[0];
            `ELLS_OFF_MASK2:     rdata[15:0] = s.staged_mask[1];
            `ELLS_OFF_MASK3:     rdata[15:0] = s.staged_mask[2];
            `ELLS_OFF_MASK4:     rdata[15:0] = s.staged_mask[3];
            `ELLS_OFF_KEEPALIVE: rdata[15:0] = s.keepalive_seconds;
            `ELLS_OFF_DIAG:      rdata[15:0] = s.network_diagnosis_select;
            `ELLS_OFF_RELAY:     rdata[15:0] = s.relay_at_reset_select;
            `ELLS_OFF_IRQ_STAT:  rdata[3:0]  = s.irq_status;
            `ELLS_OFF_IRQ_MASK:  rdata[3:0]  = s.irq_mask;
            `ELLS_OFF_LIVE:      rdata       = {s.stop_mode, 8'h0, s.snmp_enable,
                                                s.dup_ip_enable, loss2, loss1,
                                                1'b0, s.ind};
            default:             rdata = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    assign ka_limit  = 16'(s.keepalive_seconds * 16'(`ELLS_KA_MULT));
    assign ka_second = (s.ka_prescale == 32'(CYCLES_PER_SEC - 1));

    always_comb begin
        next_s = s;

        next_s.first_port_s1  = first_port_loss;
        next_s.first_port_s2  = s.first_port_s1;
        next_s.second_port_s1 = second_port_loss;
        next_s.second_port_s2 = s.second_port_s1;

        // bus answer one cycle after the request, dropped the cycle after
        next_s.rsp.ack = req;
        next_s.rsp.dat = rd ? rdata : 32'h0;

        // settings; out-of-range writes leave the old value
        if (wr16) begin
            case (a)
                `ELLS_OFF_PRIMARY:
                    if (ells_act_ok(wv)) next_s.primary_loss_action = wv;
                `ELLS_OFF_EXTENDED:
                    if (ells_act_ok(wv) || wv == `ELLS_EXT_BOTH || wv == `ELLS_EXT_EITHER)
                        next_s.extended_loss_action = wv;
                `ELLS_OFF_MASK1:
                    if (wv <= `ELLS_OCTET_MAX) next_s.staged_mask[0] = wv;
                `ELLS_OFF_MASK2:
                    if (wv <= `ELLS_OCTET_MAX) next_s.staged_mask[1] = wv;
                `ELLS_OFF_MASK3:
                    if (wv <= `ELLS_OCTET_MAX) next_s.staged_mask[2] = wv;
                `ELLS_OFF_MASK4:
                    if (wv <= `ELLS_OCTET_MAX) next_s.staged_mask[3] = wv;
                `ELLS_OFF_KEEPALIVE:
                    if (wv >= `ELLS_KA_MIN && wv <= `ELLS_KA_MAX)
                        next_s.keepalive_seconds = wv;
                `ELLS_OFF_DIAG:
                    if (wv <= `ELLS_DIAG_DUPIP || wv == `ELLS_DIAG_ALL)
                        next_s.network_diagnosis_select = wv;
                `ELLS_OFF_RELAY:
                    if (wv == `ELLS_RST_RELAY || wv == `ELLS_RELAY_ON)
                        next_s.relay_at_reset_select = wv;
                default: ;
            endcase
        end
        if (wr && wb_req.sel[0] && a == `ELLS_OFF_IRQ_MASK) begin
            next_s.irq_mask = wb_req.dat[3:0];
        end

        // mask in use only moves at a drive reset, so live traffic never
        // sees a half-written mask
        if (drive_reset) begin
            for (int i = 0; i < 4; i++) begin
                next_s.active_mask[i] = s.staged_mask[i][7:0];
            end
        end

        // warning and alarm are plain levels of the present loss
        next_s.ind.link_loss_warning = want[0];
        next_s.ind.alarm_output      = want[1];

        // trip latches; clear by control write or drive reset, a new cause wins
        if ((wr && wb_req.sel[0] && a == `ELLS_OFF_CONTROL && wb_req.dat[`ELLS_CTL_TRIP_CLR])
            || drive_reset) begin
            next_s.ind.link_loss_trip = 1'b0;
        end
        if (want_trip) begin
            next_s.ind.link_loss_trip = 1'b1;
        end
        if (want_trip && !s.ind.link_loss_trip) begin
            next_s.stop_mode = comm_error_stop_mode;
        end

        // keep-alive watchdog
        next_s.force_close = 1'b0;
        if (!connection_open || keepalive_ack) begin
            next_s.ka_prescale = 32'h0;
            next_s.ka_seconds  = 16'h0;
        end else if (ka_second) begin
            next_s.ka_prescale = 32'h0;
            if (16'(s.ka_seconds + 16'h1) >= ka_limit) begin
                next_s.force_close = 1'b1;
                next_s.ka_seconds  = 16'h0;
            end else begin
                next_s.ka_seconds = 16'(s.ka_seconds + 16'h1);
            end
        end else begin
            next_s.ka_prescale = 32'(s.ka_prescale + 32'h1);
        end

        next_s.snmp_enable = (s.network_diagnosis_select == `ELLS_DIAG_SNMP
                              || s.network_diagnosis_select == `ELLS_DIAG_ALL)
                             && !fieldbus_func;
        next_s.dup_ip_enable = s.network_diagnosis_select == `ELLS_DIAG_DUPIP
                               || s.network_diagnosis_select == `ELLS_DIAG_ALL;

        // sticky events; a read clears, an event in the same cycle survives
        ev = 4'h0;
        ev[`ELLS_IRQ_WARN]  = want[0] & ~s.ind.link_loss_warning;
        ev[`ELLS_IRQ_ALARM] = want[1] & ~s.ind.alarm_output;
        ev[`ELLS_IRQ_TRIP]  = want_trip & ~s.ind.link_loss_trip;
        ev[`ELLS_IRQ_CLOSE] = next_s.force_close;
        if (rd && a == `ELLS_OFF_IRQ_STAT) begin
            next_s.irq_status = 4'h0;
        end
        next_s.irq_status = next_s.irq_status | ev;
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s                          <= '0;
            s.primary_loss_action      <= `ELLS_RST_PRIMARY;
            s.extended_loss_action     <= `ELLS_RST_EXTENDED;
            s.staged_mask[0]           <= `ELLS_RST_MASK_HI;
            s.staged_mask[1]           <= `ELLS_RST_MASK_HI;
            s.staged_mask[2]           <= `ELLS_RST_MASK_HI;
            s.staged_mask[3]           <= `ELLS_RST_MASK_LO;
            s.active_mask[0]           <= 8'(`ELLS_RST_MASK_HI);
            s.active_mask[1]           <= 8'(`ELLS_RST_MASK_HI);
            s.active_mask[2]           <= 8'(`ELLS_RST_MASK_HI);
            s.active_mask[3]           <= 8'(`ELLS_RST_MASK_LO);
            s.keepalive_seconds        <= `ELLS_RST_KEEPALIVE;
            s.network_diagnosis_select <= `ELLS_RST_DIAG;
            s.relay_at_reset_select    <= `ELLS_RST_RELAY;
            s.irq_mask                 <= `ELLS_RST_IRQ_MASK;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp         = s.rsp;
    assign irq            = |(s.irq_status & s.irq_mask);
    assign ind            = s.ind;
    assign stop_mode      = s.stop_mode;
    assign force_close    = s.force_close;
    assign snmp_enable    = s.snmp_enable;
    assign dup_ip_enable  = s.dup_ip_enable;
    assign subnet_mask    = s.active_mask;
    assign relay_at_reset = (s.relay_at_reset_select == `ELLS_RELAY_ON);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // independent of the code decode: no loss on either port clears both levels
    property p_warn_follow;
        @(posedge clk) disable iff (!resetn)
        (!loss1 && !loss2) |=> !ind.link_loss_warning && !ind.alarm_output;
    endproperty
    a_warn_follow: assert property (p_warn_follow)
        else $error("warning or alarm held after the signal returned");

    property p_alarm_needs_code2;
        @(posedge clk) disable iff (!resetn)
        $rose(ind.alarm_output) |-> ($past(s.primary_loss_action) == `ELLS_ACT_ALARM
                                    || $past(s.extended_loss_action) == `ELLS_ACT_ALARM);
    endproperty
    a_alarm_needs_code2: assert property (p_alarm_needs_code2)
        else $error("alarm raised without an alarm code");

    property p_both_ports;
        @(posedge clk) disable iff (!resetn)
        (s.extended_loss_action == `ELLS_EXT_BOTH && !(loss1 && loss2))
        |=> !ind.link_loss_warning;
    endproperty
    a_both_ports: assert property (p_both_ports)
        else $error("warning with loss on only one port in both-port mode");

    property p_either_port;
        @(posedge clk) disable iff (!resetn)
        (s.extended_loss_action == `ELLS_EXT_EITHER
         && s.primary_loss_action == `ELLS_ACT_WARN && (loss1 || loss2))
        |=> ind.link_loss_warning;
    endproperty
    a_either_port: assert property (p_either_port)
        else $error("no warning on single-port loss in either-port mode");

    property p_second_port_own_code;
        @(posedge clk) disable iff (!resetn)
        (s.extended_loss_action == `ELLS_ACT_OFF && !loss1 && loss2)
        |=> !ind.link_loss_warning && !ind.alarm_output;
    endproperty
    a_second_port_own_code: assert property (p_second_port_own_code)
        else $error("second port loss acted despite extended code off");

    property p_stopped_no_trip;
        @(posedge clk) disable iff (!resetn)
        (drive_stopped && !fieldbus_cyclic && !ind.link_loss_trip) |=> !ind.link_loss_trip;
    endproperty
    a_stopped_no_trip: assert property (p_stopped_no_trip)
        else $error("trip while drive stopped");

    property p_fieldbus_trip;
        @(posedge clk) disable iff (!resetn)
        (fieldbus_cyclic && (loss1 || loss2)) |=> ind.link_loss_trip;
    endproperty
    a_fieldbus_trip: assert property (p_fieldbus_trip)
        else $error("fieldbus loss did not trip");

    property p_stop_mode_taken;
        @(posedge clk) disable iff (!resetn)
        $rose(ind.link_loss_trip) |-> stop_mode == $past(comm_error_stop_mode);
    endproperty
    a_stop_mode_taken: assert property (p_stop_mode_taken)
        else $error("stop mode not captured at trip");

    property p_snmp_blocked;
        @(posedge clk) disable iff (!resetn)
        fieldbus_func |=> !snmp_enable;
    endproperty
    a_snmp_blocked: assert property (p_snmp_blocked)
        else $error("snmp on with fieldbus function selected");

    property p_mask_held;
        @(posedge clk) disable iff (!resetn)
        !drive_reset |=> $stable(subnet_mask);
    endproperty
    a_mask_held: assert property (p_mask_held)
        else $error("subnet mask changed without drive reset");

    property p_close_timing;
        @(posedge clk) disable iff (!resetn)
        force_close |-> $past(connection_open) && !$past(keepalive_ack)
                        && $past(s.ka_seconds) == 16'($past(ka_limit) - 16'h1);
    endproperty
    a_close_timing: assert property (p_close_timing)
        else $error("connection closed before eight keep-alive periods");

    property p_ack_one;
        @(posedge clk) disable iff (!resetn)
        wb_rsp.ack |=> !wb_rsp.ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held longer than one cycle");

endmodule

//--- verif/ells_net_model.sv
// network side of the supervisor: phy signal state, connection and keep-alive acks
// assumes the bench steers it through level requests on the same clock
module ells_net_model (
    // bench requests
    input  wire logic clk,
    input  wire logic lose1,
    input  wire logic lose2,
    input  wire logic open_req,
    input  wire logic ack_on,
    // pins toward the supervisor
    output      logic first_port_loss,
    output      logic second_port_loss,
    output      logic connection_open,
    output      logic keepalive_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] tick;
    initial begin
        tick = 4'h0;
        {first_port_loss, second_port_loss, connection_open, keepalive_ack} = 4'h0;
    end
    always @(posedge clk) begin
        tick <= tick + 4'h1;
        first_port_loss <= lose1;
        second_port_loss <= lose2;
        connection_open <= open_req;
        // acks every 16 cycles, well inside the shortest watchdog span
        keepalive_ack <= ack_on && open_req && (tick == 4'hF);
    end
endmodule

//--- verif/ells_top_bench.sv
// testbench of the link loss supervisor: bus, loss response, keep-alive, settings
// assumes ells_top with a short second (CYCLES_PER_SEC 4) and the network model
`include "ells_regs.svh"

module ells_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ells_pkg::*;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    ells_wb_req_t     wb_req = '0;
    ells_wb_rsp_t     wb_rsp;
    ells_ind_t        ind;
    logic             dstop = 1'b0, dres = 1'b0, fcyc = 1'b0;
    logic             l1r = 1'b0, l2r = 1'b0, opr = 1'b0, acr = 1'b0;
    logic             l1, l2, copen, kack, irq, fclose, snmp, dup, relay;
    logic [3:0][15:0] fsel = '0;
    logic [15:0]      smode = '0, stop_mode;
    logic [31:0]      mask, rd;
    int               errors = 0, cmp_count = 0;
    localparam logic [15:0] EXT [6] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22B8, 16'h270F};
    localparam logic [15:0] RST [9] = '{16'h3, 16'h270F, 16'hFF, 16'hFF, 16'hFF, 16'h0,
                                        16'h3C, 16'h270F, 16'h0};

    ells_net_model net (.clk(clk), .lose1(l1r), .lose2(l2r), .open_req(opr), .ack_on(acr),
        .first_port_loss(l1), .second_port_loss(l2), .connection_open(copen),
        .keepalive_ack(kack));
    ells_top #(.CYCLES_PER_SEC(4)) uut (.clk(clk), .resetn(resetn), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .irq(irq), .first_port_loss(l1), .second_port_loss(l2),
        .drive_stopped(dstop), .drive_reset(dres), .fieldbus_cyclic(fcyc),
        .function_select(fsel), .comm_error_stop_mode(smode), .connection_open(copen),
        .keepalive_ack(kack), .ind(ind), .stop_mode(stop_mode), .force_close(fclose),
        .snmp_enable(snmp), .dup_ip_enable(dup), .subnet_mask(mask), .relay_at_reset(relay));

////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one classic cycle; the slave's latency is not assumed
    task automatic wbt(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        if (wb_rsp.ack !== 1'b1) begin
            errors++;
            stop_test();
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk);
    endtask

    function automatic logic [2:0] code_ind(input logic [15:0] c);
        case (c)
            16'h1: return 3'b100;
            16'h2: return 3'b110;
            16'h3: return 3'b001;
            default: return 3'b000;
        endcase
    endfunction

    // {warning, alarm, trip} for the present settings and drive state
    function automatic logic [2:0] exp_ind(input logic [15:0] p, e, input logic a, b);
        logic [2:0] r;
        if (e == 16'h22B8) r = (a && b) ? code_ind(p) : 3'b000;
        else if (e == 16'h270F) r = (a || b) ? code_ind(p) : 3'b000;
        else r = (a ? code_ind(p) : 3'b000) | (b ? code_ind(e) : 3'b000);
        if (dstop) r[0] = 1'b0;
        if (fcyc && (a || b)) r[0] = 1'b1;
        return r;
    endfunction

////////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;

    initial begin
        logic [15:0]      p, e, d;
        logic [31:0]      o;
        logic [3:0][15:0] f;
        logic [2:0]       x;
        logic             a, b;
        int               n;
        void'($urandom(32'h37A0AE13));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("mask_rst", 32'h00FFFFFF, mask);
        for (int i = 0; i < 9; i++) begin
            wbt(1'b0, 8'(i * 4), 32'h0);
            chk("reg_rst", {16'h0, RST[i]}, rd);
        end
        wbt(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, rd);
        wbt(1'b1, `ELLS_OFF_PRIMARY, 32'h4);
        wbt(1'b0, `ELLS_OFF_PRIMARY, 32'h0);
        chk("prim_range", 32'h3, rd);
        wbt(1'b1, `ELLS_OFF_MASK1, 32'h100);
        wbt(1'b0, `ELLS_OFF_MASK1, 32'h0);
        chk("mask_range", 32'hFF, rd);
        wbt(1'b1, `ELLS_OFF_KEEPALIVE, 32'h1C21);
        wbt(1'b0, `ELLS_OFF_KEEPALIVE, 32'h0);
        chk("ka_range", 32'h3C, rd);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            p = 16'($urandom_range(3));
            e = EXT[i % 6];
            a = ($urandom_range(3) != 0);
            b = ($urandom_range(3) != 0);
            wbt(1'b1, `ELLS_OFF_PRIMARY, {16'h0, p});
            wbt(1'b1, `ELLS_OFF_EXTENDED, {16'h0, e});
            l1r <= a;
            l2r <= b;
            dstop <= 1'($urandom);
            fcyc <= (i % 5 == 4);
            smode <= 16'($urandom);
            repeat (6) @(posedge clk);
            x = exp_ind(p, e, a, b);
            chk("ind", x, ind);
            if (x[0]) chk("stop_mode", smode, stop_mode);
            l1r <= 1'b0;
            l2r <= 1'b0;
            repeat (6) @(posedge clk);
            chk("ind_release", 2'b00, ind[2:1]);
            wbt(1'b1, `ELLS_OFF_CONTROL, 32'h1);
            @(posedge clk);
            chk("trip_clear", 1'b0, ind.link_loss_trip);
        end
        dstop <= 1'b0;
        fcyc <= 1'b0;
        $display("test loss done");
        o = $urandom;
        for (int i = 0; i < 4; i++) wbt(1'b1, 8'(8 + 4 * i), {24'h0, o[8 * i +: 8]});
        @(posedge clk);
        chk("mask_hold", 32'h00FFFFFF, mask);
        dres <= 1'b1;
        @(posedge clk);
        dres <= 1'b0;
        repeat (2) @(posedge clk);
        chk("mask_new", o, mask);
        $display("test mask done");
        for (int i = 0; i < 8; i++) begin
            d = (i % 4 == 3) ? 16'h270F : 16'(i % 4);
            f = '0;
            if (i > 3) f[$urandom_range(3)] = 16'h8892;
            fsel <= f;
            wbt(1'b1, `ELLS_OFF_DIAG, {16'h0, d});
            repeat (2) @(posedge clk);
            chk("diag", {d[0] && i < 4, d[1]}, {snmp, dup});
        end
        chk("relay_rst", 1'b0, relay);
        wbt(1'b1, `ELLS_OFF_RELAY, 32'h270F);
        @(posedge clk);
        chk("relay", 1'b1, relay);
        $display("test diag done");
        wbt(1'b1, `ELLS_OFF_KEEPALIVE, 32'h1);
        wbt(1'b1, `ELLS_OFF_IRQ_MASK, 32'h8);
        wbt(1'b0, `ELLS_OFF_IRQ_STAT, 32'h0);
        chk("irq_idle", 1'b0, irq);
        opr <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (fclose !== 1'b1 && n < 60);
        opr <= 1'b0;
        chk("ka_time", 1'b1, n >= 32 && n <= 36);
        repeat (2) @(posedge clk);
        chk("irq_set", 1'b1, irq);
        wbt(1'b0, `ELLS_OFF_IRQ_STAT, 32'h0);
        chk("irq_stat", 1'b1, rd[3]);
        chk("irq_clear", 1'b0, irq);
        opr <= 1'b1;
        acr <= 1'b1;
        n = 0;
        repeat (100) begin
            @(posedge clk);
            n += int'(fclose === 1'b1);
        end
        chk("ka_acked", 32'h0, n);
        $display("test keepalive done");
        stop_test();
    end
endmodule
